/* File: shared/ufm_rx_pkg.sv */
// Purpose: Shared constants and types for the receive-only two-wire slave
// Assumes: Bus master drives both lines; device only listens
// Notes:   Event word layout is shared by the receiver and its crossing

package ufm_rx_pkg;

	// ----------------------------------------------------------------
	// Clocks and bus rate
	// ----------------------------------------------------------------
	localparam int unsigned SYS_CLK_HZ  = 25_000_000;	// System clock rate
	localparam int unsigned MAX_SCL_HZ  = 5_000_000;	// Fastest bus clock

	// ----------------------------------------------------------------
	// Byte framing
	// ----------------------------------------------------------------
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;	// Index of eighth data bit
	localparam logic [3:0] FILL_BIT      = 4'h8;	// Index of fixed-1 ninth bit
	localparam logic [3:0] BIT_CNT_RST   = 4'h0;	// Bit counter reset value
	localparam logic [7:0] SHIFT_RST     = 8'h00;	// Shift register reset value

	// ----------------------------------------------------------------
	// Software reset call bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] GEN_CALL_WR   = 8'h00;	// General call, write bit 0
	localparam logic [7:0] SOFT_RST_BYTE = 8'h06;	// Reset command data byte

	// ----------------------------------------------------------------
	// Event word passed from link domain to system domain
	// ----------------------------------------------------------------
	localparam int unsigned EV_W     = 11;	// Event word width
	localparam int unsigned EV_STOP  = 10;	// Stop seen
	localparam int unsigned EV_SRST  = 9;	// Stop closes a valid reset call
	localparam int unsigned EV_FIRST = 8;	// Byte is the address byte
	localparam logic [10:0] EV_RST   = 11'h000;	// Event word reset value

	// ----------------------------------------------------------------
	// Link receiver states
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		LNK_IDLE = 1'b0,	// Bus free, waiting for start
		LNK_RECV = 1'b1		// Inside a transfer
	} link_state_t;

endpackage

/* File: test/ufm_bus_master.sv */
// Purpose: Bus master model that drives both lines of the two-wire link
// Assumes: Push-pull master, 5 MHz bit rate (100 ns clock high, 100 ns low)
// Notes:   Tasks are called from the bench; lines rest high after each stop

`timescale 1ns/1ps

module ufm_bus_master (
	// Bus lines, master driven
	output logic scl,
	output logic sda
);
	// ----------------------------------------------------------------
	// Line control
	// ----------------------------------------------------------------
	// Idle bus: both lines high
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Start or repeated start: data falls while clock is high
	task automatic start();
		sda = 1'b1;
		#50;
		scl = 1'b1;
		#100;
		sda = 1'b0;
		#100;
		scl = 1'b0;
		#50;
	endtask

	// One bit; data only moves while clock is low
	task automatic send_bit(input logic v);
		sda = v;
		#50;
		scl = 1'b1;
		#100;
		scl = 1'b0;
		#50;
	endtask

	// Eight bits MSB first, then the ninth fill bit
	task automatic send_byte(input logic [7:0] v, input logic fill);
		for (int i = 7; i >= 0; i--) begin
			send_bit(v[i]);
		end
		send_bit(fill);
	endtask

	// Stop: gap of one bit time, then data rises while clock is high
	task automatic stop();
		scl = 1'b0;
		#200;
		sda = 1'b0;
		#50;
		scl = 1'b1;
		#100;
		sda = 1'b1;
		#200;
	endtask
endmodule // ufm_bus_master

/* File: test/ufm_write_only_receiver_tb.sv */
// Purpose: Self-checking bench for the receive-only two-wire slave
// Assumes: Master model drives the bus; queue model predicts every event
// Notes:   Byte entries are addr*256+data; end entries are 512+reset flag

`timescale 1ns/1ps

module ufm_write_only_receiver_tb;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic       sys_clk;	// System clock, 40 ns
	logic       reset_n;	// Active-low reset
	logic       link_clk;	// Oversampling clock, 6 ns
	wire        scl;	// Bus clock line
	wire        sda;	// Bus data line
	logic       sda_out;	// Unused data pin value
	logic       sda_oe;	// Data pin enable, must stay low
	logic [7:0] rx_data_r;	// Received byte
	logic       rx_valid_r;	// Byte strobe
	logic       rx_addr_r;	// First byte flag
	logic       rx_end_r;	// Stop strobe
	logic       soft_reset_call_r;	// Reset call strobe
	int         err_total;	// Mismatch count
	int         n_checks;	// Comparison count
	int         seed;	// Random seed
	int         exp_q[$];	// Expected events in order
	int         d[$];	// Bytes of the next frame
	bit         rnd_fill;	// Randomise ninth bit

	// ----------------------------------------------------------------
	// Instances
	// ----------------------------------------------------------------
	ufm_write_only_receiver ufm_write_only_receiver_i (
		.sys_clk                (sys_clk),
		.reset_n                (reset_n),
		.link_clk               (link_clk),
		.serial_clock_line      (scl),
		.serial_data_line       (sda),
		.serial_data_line_out_r (sda_out),
		.serial_data_line_oe_r  (sda_oe),
		.rx_data_r              (rx_data_r),
		.rx_valid_r             (rx_valid_r),
		.rx_addr_r              (rx_addr_r),
		.rx_end_r               (rx_end_r),
		.soft_reset_call_r      (soft_reset_call_r)
	);

	ufm_bus_master host_i (
		.scl (scl),
		.sda (sda)
	);

	// ----------------------------------------------------------------
	// Clocks; link clock offset so the two never line up
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	// ----------------------------------------------------------------
	// Compare tasks and verdict
	// ----------------------------------------------------------------
	task automatic chk_byte(input logic [10:0] got, input logic [10:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch byte t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_end(input logic [2:0] got, input logic [2:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch end t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Monitor: every strobe pops one expected event (empty queue fails)
	// ----------------------------------------------------------------
	always @(negedge sys_clk) begin
		int e;
		e = 0;
		if ((rx_valid_r || rx_end_r || soft_reset_call_r) && exp_q.size() == 0) begin
			// Unexpected strobe: middle bit is set, so this always mismatches
			chk_end({sda_oe, rx_valid_r | rx_end_r, soft_reset_call_r}, 3'b000);
		end else if (rx_valid_r || rx_end_r || soft_reset_call_r) begin
			e = exp_q.pop_front();
			if (rx_valid_r) begin
				chk_byte({sda_oe, rx_end_r, rx_addr_r, rx_data_r}, {2'b00, e[8:0]});
			end else begin
				chk_end({sda_oe, rx_end_r, soft_reset_call_r}, {1'b0, e[9], e[0]});
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame task: sends d[], predicts bytes and the reset call
	// ----------------------------------------------------------------
	task automatic frame(input bit with_stop);
		bit armed;
		logic fill;
		armed = 1'b0;
		host_i.start();
		foreach (d[i]) begin
			fill = rnd_fill ? 1'($random(seed)) : 1'b1;
			// Predict first: the strobe arrives before the ninth bit ends
			exp_q.push_back((i == 0) * 256 + d[i]);
			host_i.send_byte(d[i][7:0], fill);
			if (i == 1) begin
				armed = (d[0] == 0) && (d[1] == 6);
			end
		end
		d.delete();
		if (with_stop) begin
			exp_q.push_back(512 + armed);
			host_i.stop();
			#1000;
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		err_total = 0;
		n_checks = 0;
		seed = 23;
		rnd_fill = 1'b0;
		repeat (4) @(negedge sys_clk);
		reset_n = 1'b1;
		#500;
		// Short and long transfers with random bytes
		for (int n = 1; n <= 20; n += 19) begin
			for (int i = 0; i < n; i++) begin
				d.push_back($random(seed) & 8'hFF);
			end
			frame(1'b1);
		end
		// Reset call with extra bytes, then wrong command byte
		d = '{8'h00, 8'h06, 8'hA5, 8'h3C};
		frame(1'b1);
		d = '{8'h00, 8'h07};
		frame(1'b1);
		// Ninth bit driven at random values
		rnd_fill = 1'b1;
		d = '{8'h00, 8'h06, 8'h81};
		frame(1'b1);
		rnd_fill = 1'b0;
		// Partial byte then repeated start; armed call then restart
		host_i.start();
		for (int i = 0; i < 4; i++) begin
			host_i.send_bit(1'($random(seed)));
		end
		d = '{8'h00, 8'h06};
		frame(1'b0);
		d = '{8'h55};
		frame(1'b1);
		// Stop from idle must stay silent
		host_i.stop();
		#1000;
		chk_end({sda_oe, sda_out, exp_q.size() != 0}, 3'b000);
		finish_test();
	end

	// ----------------------------------------------------------------
	// Watchdog: whole run is well under 2 ms of bus time
	// ----------------------------------------------------------------
	initial begin
		#2_000_000;
		err_total++;
		finish_test();
	end
endmodule // ufm_write_only_receiver_tb

/* File: verilog/ufm_rx_handshake.sv */
// Purpose: Carries event words from the link clock to the system clock
// Assumes: Sender waits for busy low before each send
// Notes:   Toggle request with returned acknowledge; word held while busy

`timescale 1ns/1ps

module ufm_rx_handshake (
	// Link side
	input  wire logic                       link_clk,
	input  wire logic                       link_rst_n,
	input  wire logic                       ev_send,
	input  wire logic [ufm_rx_pkg::EV_W-1:0] ev_word,
	output logic                            link_busy,
	// System side
	input  wire logic                       sys_clk,
	input  wire logic                       reset_n,
	output logic [ufm_rx_pkg::EV_W-1:0]     sys_word,
	output logic                            sys_valid
);

	// ----------------------------------------------------------------
	// Link side: request toggle and held word
	// ----------------------------------------------------------------
	logic                        req_tgl_r;	// Flips once per event
	logic [ufm_rx_pkg::EV_W-1:0] hold_r;	// Stable until acknowledged
	logic                        ack_m_r;	// Ack synchroniser stage 1
	logic                        ack_s_r;	// Ack synchroniser stage 2
	logic                        req_m_r;	// Stage 1, read only by stage 2
	logic                        req_s_r;	// Stage 2 of request synchroniser
	logic                        req_d_r;	// Edge detect, also the acknowledge

	// Capture word and flip request on send
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			req_tgl_r <= 1'b0;
			hold_r    <= ufm_rx_pkg::EV_RST;
		end else if (ev_send) begin
			req_tgl_r <= ~req_tgl_r;
			hold_r    <= ev_word;
		end
	end

	// Bring acknowledge back into link domain
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ack_m_r <= 1'b0;
			ack_s_r <= 1'b0;
		end else begin
			// Ack leaves only once the word is captured, so hold_r stays put
			ack_m_r <= req_d_r;
			ack_s_r <= ack_m_r;
		end
	end

	// Busy until the far side has echoed the toggle
	assign link_busy = req_tgl_r ^ ack_s_r;

	// ----------------------------------------------------------------
	// System side: request synchroniser and word capture
	// ----------------------------------------------------------------
	// Synchronise request toggle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_m_r <= 1'b0;
			req_s_r <= 1'b0;
			req_d_r <= 1'b0;
		end else begin
			req_m_r <= req_tgl_r;
			req_s_r <= req_m_r;
			req_d_r <= req_s_r;
		end
	end

	// Held word is stable once request edge is seen
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sys_word  <= ufm_rx_pkg::EV_RST;
			sys_valid <= 1'b0;
		end else begin
			sys_valid <= req_s_r ^ req_d_r;
			if (req_s_r ^ req_d_r) begin
				sys_word <= hold_r;
			end
		end
	end

endmodule // ufm_rx_handshake

/* File: verilog/ufm_write_only_receiver.sv */
// Purpose: Receive-only slave front end for an ultra-fast two-wire bus
// Assumes: link_clk oversamples the bus well above the bus clock rate
// Notes:   Bytes, stop and reset call are reported in the sys_clk domain

`timescale 1ns/1ps

// Notes on behaviour
// - Two master-driven lines, up to 5 MHz.
// - Write-only slave, data line never driven.
// - One data bit per clock pulse.
// - Data change while clock high is control.
// - Both lines high means idle bus.
// - Data fall with clock high starts.
// - Data rise with clock high stops.
// - Unlimited bytes between start and stop.
// - Reset call: general call, then byte 06h.
// - Extra bytes ignored; reset after stop.
module ufm_write_only_receiver (
	// System clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// Bus pins and oversampling link clock
	input  wire logic       link_clk,
	input  wire logic       serial_clock_line,
	input  wire logic       serial_data_line,
	output logic            serial_data_line_out_r,
	output logic            serial_data_line_oe_r,
	// Received stream, system domain
	output logic [7:0]      rx_data_r,
	output logic            rx_valid_r,
	output logic            rx_addr_r,
	output logic            rx_end_r,
	output logic            soft_reset_call_r
);

	// ----------------------------------------------------------------
	// Link domain reset
	// ----------------------------------------------------------------
	logic lrst_m_r;	// Release synchroniser stage 1
	logic lrst_n;	// Link reset, released on link_clk

	// Assert at once, release clean on link clock
	always_ff @(posedge link_clk or negedge reset_n) begin
		if (!reset_n) begin
			lrst_m_r <= 1'b0;
			lrst_n   <= 1'b0;
		end else begin
			lrst_m_r <= 1'b1;
			lrst_n   <= lrst_m_r;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and condition detect
	// ----------------------------------------------------------------
	logic scl_m_r, scl_s_r, scl_d_r;	// Clock pin stages
	logic sda_m_r, sda_s_r, sda_d_r;	// Data pin stages

	// Equal depth on both pins keeps their skew intact
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_m_r <= serial_clock_line;
			scl_s_r <= scl_m_r;
			scl_d_r <= scl_s_r;
			sda_m_r <= serial_data_line;
			sda_s_r <= sda_m_r;
			sda_d_r <= sda_s_r;
		end
	end

	logic scl_high;	// Clock held high over two samples
	logic start_det;	// Start condition
	logic stop_det;	// Stop condition
	logic scl_rise;	// Sampling edge for a bit

	assign scl_high  = scl_s_r & scl_d_r;
	assign start_det = scl_high & sda_d_r & ~sda_s_r;
	assign stop_det  = scl_high & ~sda_d_r & sda_s_r;
	assign scl_rise  = scl_s_r & ~scl_d_r;

	// ----------------------------------------------------------------
	// Receive state machine and bit counter
	// ----------------------------------------------------------------
	ufm_rx_pkg::link_state_t state_r;	// Idle or in transfer
	logic [3:0]              bit_cnt_r;	// Slot in current byte, 0..8
	logic [7:0]              shift_r;	// Data bits, MSB first
	logic                    first_r;	// Next byte is the address
	logic                    byte_done;	// Eighth data bit sampled now

	assign byte_done = (state_r == ufm_rx_pkg::LNK_RECV) & scl_rise & ~start_det & ~stop_det
		& (bit_cnt_r == ufm_rx_pkg::LAST_DATA_BIT);

	// Start wins over everything, stop ends, else count bits
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			state_r   <= ufm_rx_pkg::LNK_IDLE;
			bit_cnt_r <= ufm_rx_pkg::BIT_CNT_RST;
		end else if (start_det) begin
			// Partial byte dropped, address expected again
			state_r   <= ufm_rx_pkg::LNK_RECV;
			bit_cnt_r <= ufm_rx_pkg::BIT_CNT_RST;
		end else if (stop_det) begin
			state_r   <= ufm_rx_pkg::LNK_IDLE;
			bit_cnt_r <= ufm_rx_pkg::BIT_CNT_RST;
		end else if (state_r == ufm_rx_pkg::LNK_RECV && scl_rise) begin
			// Fixed-1 ninth slot counted but never inspected
			if (bit_cnt_r == ufm_rx_pkg::FILL_BIT) begin
				bit_cnt_r <= ufm_rx_pkg::BIT_CNT_RST;
			end else begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end
	end

	// Shift in on rising clock only; high-phase changes never shift
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			shift_r <= ufm_rx_pkg::SHIFT_RST;
		end else if (state_r == ufm_rx_pkg::LNK_RECV && scl_rise && !start_det && !stop_det
			&& bit_cnt_r != ufm_rx_pkg::FILL_BIT) begin
			shift_r <= {shift_r[6:0], sda_s_r};
		end
	end

	// Address flag: set by start, cleared after first byte; no byte limit
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			first_r <= 1'b1;
		end else if (start_det) begin
			first_r <= 1'b1;
		end else if (byte_done) begin
			first_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software reset call tracking
	// ----------------------------------------------------------------
	logic [7:0] new_byte;	// Byte completed this cycle
	logic       gc_r;	// Address byte was the general call
	logic       second_r;	// Next byte is the first data byte
	logic       arm_r;	// Valid call seen, waits for stop

	assign new_byte = {shift_r[6:0], sda_s_r};

	// Only the first data byte counts; later bytes leave arm_r alone
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			gc_r     <= 1'b0;
			second_r <= 1'b0;
			arm_r    <= 1'b0;
		end else if (start_det || stop_det) begin
			gc_r     <= 1'b0;
			second_r <= 1'b0;
			arm_r    <= 1'b0;
		end else if (byte_done) begin
			if (first_r) begin
				gc_r     <= (new_byte == ufm_rx_pkg::GEN_CALL_WR);
				second_r <= 1'b1;
			end else begin
				second_r <= 1'b0;
				if (second_r && gc_r && new_byte == ufm_rx_pkg::SOFT_RST_BYTE) begin
					arm_r <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Event queue toward the system domain
	// ----------------------------------------------------------------
	logic                        byte_pend_r;	// Byte waiting to cross
	logic                        stop_pend_r;	// Stop waiting to cross
	logic                        srst_pend_r;	// Stop closes reset call
	logic [7:0]                  data_pend_r;	// Byte value waiting
	logic                        addr_pend_r;	// Waiting byte is address
	logic                        link_busy;	// Crossing still in flight
	logic                        send_byte;	// Byte goes now
	logic                        send_stop;	// Stop goes now
	logic [ufm_rx_pkg::EV_W-1:0] ev_word;	// Word handed to crossing

	// Byte first so a stop never overtakes the data before it
	assign send_byte = byte_pend_r & ~link_busy;
	assign send_stop = stop_pend_r & ~byte_pend_r & ~link_busy;
	assign ev_word   = send_stop ? {1'b1, srst_pend_r, 1'b0, 8'h00}
		: {1'b0, 1'b0, addr_pend_r, data_pend_r};

	// Set wins over clear so no event is dropped
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			byte_pend_r <= 1'b0;
			data_pend_r <= ufm_rx_pkg::SHIFT_RST;
			addr_pend_r <= 1'b0;
		end else if (byte_done) begin
			byte_pend_r <= 1'b1;
			data_pend_r <= new_byte;
			addr_pend_r <= first_r;
		end else if (send_byte) begin
			byte_pend_r <= 1'b0;
		end
	end

	// Stop from idle is ignored; only a transfer is closed
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			stop_pend_r <= 1'b0;
			srst_pend_r <= 1'b0;
		end else if (stop_det && state_r == ufm_rx_pkg::LNK_RECV) begin
			stop_pend_r <= 1'b1;
			srst_pend_r <= arm_r;
		end else if (send_stop) begin
			stop_pend_r <= 1'b0;
		end
	end

	// Receive-only: data pin output is never enabled
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			serial_data_line_out_r <= 1'b0;
			serial_data_line_oe_r  <= 1'b0;
		end else begin
			serial_data_line_out_r <= 1'b0;
			serial_data_line_oe_r  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Domain crossing and system outputs
	// ----------------------------------------------------------------
	logic [ufm_rx_pkg::EV_W-1:0] sys_word;	// Event in system domain
	logic                        sys_valid;	// One-cycle arrival

	ufm_rx_handshake u_xfer (
		.link_clk   (link_clk),
		.link_rst_n (lrst_n),
		.ev_send    (send_byte | send_stop),
		.ev_word    (ev_word),
		.link_busy  (link_busy),
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.sys_word   (sys_word),
		.sys_valid  (sys_valid)
	);

	// Decode arriving event into registered outputs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_data_r         <= ufm_rx_pkg::SHIFT_RST;
			rx_valid_r        <= 1'b0;
			rx_addr_r         <= 1'b0;
			rx_end_r          <= 1'b0;
			soft_reset_call_r <= 1'b0;
		end else begin
			rx_valid_r        <= sys_valid & ~sys_word[ufm_rx_pkg::EV_STOP];
			rx_end_r          <= sys_valid & sys_word[ufm_rx_pkg::EV_STOP];
			soft_reset_call_r <= sys_valid & sys_word[ufm_rx_pkg::EV_STOP]
				& sys_word[ufm_rx_pkg::EV_SRST];
			if (sys_valid && !sys_word[ufm_rx_pkg::EV_STOP]) begin
				rx_data_r <= sys_word[7:0];
				rx_addr_r <= sys_word[ufm_rx_pkg::EV_FIRST];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic recv;	// In transfer
	assign recv = (state_r == ufm_rx_pkg::LNK_RECV);

	chk_sda_undriven: assert property (@(posedge link_clk) disable iff (!lrst_n)
		!serial_data_line_oe_r) else $error("data line output enabled");
	chk_start_restarts: assert property (@(posedge link_clk) disable iff (!lrst_n)
		start_det |=> recv && bit_cnt_r == 4'h0 && first_r) else $error("start did not restart");
	chk_stop_to_idle: assert property (@(posedge link_clk) disable iff (!lrst_n)
		stop_det && !start_det |=> !recv) else $error("stop did not idle");
	chk_bit_per_pulse: assert property (@(posedge link_clk) disable iff (!lrst_n)
		recv && scl_rise && !start_det && !stop_det && bit_cnt_r < 4'h8
		|=> bit_cnt_r == $past(bit_cnt_r) + 4'h1 && shift_r[0] == $past(sda_s_r))
		else $error("bit not captured");
	chk_ninth_ignored: assert property (@(posedge link_clk) disable iff (!lrst_n)
		recv && scl_rise && !start_det && !stop_det && bit_cnt_r == 4'h8
		|=> bit_cnt_r == 4'h0 && $stable(shift_r) && recv) else $error("ninth slot mishandled");
	chk_high_no_data: assert property (@(posedge link_clk) disable iff (!lrst_n)
		scl_high && (sda_s_r != sda_d_r) |=> $stable(shift_r)) else $error("data shifted in high");
	chk_idle_holds: assert property (@(posedge link_clk) disable iff (!lrst_n)
		!recv && !start_det |=> !recv) else $error("left idle without start");
	chk_bytes_unlimited: assert property (@(posedge link_clk) disable iff (!lrst_n)
		byte_done |=> byte_pend_r && recv) else $error("byte dropped");
	chk_reset_on_stop: assert property (@(posedge sys_clk) disable iff (!reset_n)
		soft_reset_call_r |-> rx_end_r && !rx_valid_r) else $error("reset call without stop");
	chk_reset_armed: assert property (@(posedge link_clk) disable iff (!lrst_n)
		$rose(arm_r) |-> $past(gc_r) && !first_r) else $error("reset armed without call");

	cov_byte: cover property (@(posedge link_clk) disable iff (!lrst_n) byte_done && !first_r);
	cov_soft_reset: cover property (@(posedge sys_clk) disable iff (!reset_n) soft_reset_call_r);
	cov_mid_start: cover property (@(posedge link_clk) disable iff (!lrst_n)
		start_det && recv && bit_cnt_r != 4'h0);

endmodule // ufm_write_only_receiver
